// ==== pkg/sbc_cfg_pkg.sv ====
/*
  constants shared by the pin-function, pwm and limit configuration block:
  register addresses, field layout, reset values, pin mode codes and the
  cycle counts derived from the 125 mhz system clock.
  assumes one clock domain and a 7-bit spi register address space.
*/
`default_nettype none
package sbc_cfg_pkg;
    // register addresses on the spi frame
    localparam logic [6:0] ADDR_PIN_FUNC = 7'h17;
    localparam logic [6:0] ADDR_DUTY     = 7'h18;
    localparam logic [6:0] ADDR_RATE     = 7'h1c;
    localparam logic [6:0] ADDR_HWCTL    = 7'h1d;

    // field positions and widths
    localparam int PIN_MODE_LSB = 0;
    localparam int PIN_MODE_W   = 3;
    localparam int RATE_LSB     = 0;
    localparam int RATE_W       = 2;
    localparam int TRIP_POS     = 2;
    localparam int ILIM_LSB     = 0;
    localparam int ILIM_W       = 2;

    // reset values
    localparam logic [2:0] PIN_MODE_POR = 3'h0;
    localparam logic [7:0] DUTY_POR     = 8'h00;
    localparam logic [1:0] RATE_POR     = 2'h0;
    localparam logic [7:0] HWCTL_POR    = 8'h01;
    localparam logic       TRIP_POR     = 1'h0;
    localparam logic [1:0] ILIM_POR     = 2'h1;

    // duty settings with fixed meaning
    localparam logic [7:0] DUTY_OFF  = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;

    typedef enum logic [2:0] {
        PM_FAIL0    = 3'b000,
        PM_FAIL1    = 3'b001,
        PM_FAIL2    = 3'b010,
        PM_HS_TIMER = 3'b011,
        PM_OFF      = 3'b100,
        PM_WAKE     = 3'b101,
        PM_LS_PWM   = 3'b110,
        PM_HS_PWM   = 3'b111
    } pin_mode_t;

    // one-hot pin function vector positions
    localparam int FN_FAIL  = 0;
    localparam int FN_HS_TM = 1;
    localparam int FN_OFF   = 2;
    localparam int FN_WAKE  = 3;
    localparam int FN_LS_PW = 4;
    localparam int FN_HS_PW = 5;
    localparam int FN_W     = 6;

    // timing
    localparam int CLK_HZ        = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PWM_STEPS     = 255;
    localparam int RATE0_HZ      = 100;
    localparam int RATE1_HZ      = 200;
    localparam int RATE2_HZ      = 325;
    localparam int RATE3_HZ      = 400;
    // longest step that still fits the period: round down
    localparam int STEP_CYC0 = CLK_HZ / (RATE0_HZ * PWM_STEPS);
    localparam int STEP_CYC1 = CLK_HZ / (RATE1_HZ * PWM_STEPS);
    localparam int STEP_CYC2 = CLK_HZ / (RATE2_HZ * PWM_STEPS);
    localparam int STEP_CYC3 = CLK_HZ / (RATE3_HZ * PWM_STEPS);
    localparam int STEP_CNT_W = 13;
    localparam int WAKE_FILTER_NS  = 16_000;
    // least time: round up
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 11;

    // spi frame: 8 address/command bits then 8 data bits, lsb first
    localparam logic [4:0] SPI_LAST_CMD_BIT  = 5'd7;
    localparam logic [4:0] SPI_FIRST_DAT_BIT = 5'd8;
    localparam logic [4:0] SPI_LAST_BIT      = 5'd15;
    localparam logic [4:0] SPI_DONE          = 5'd16;
endpackage
`default_nettype wire

// ==== hdl/pwm_gen.sv ====
/*
  pwm generator: 255 steps per period, duty and rate taken only at the
  period boundary.
  assumes duty and rate come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_gen #(
    parameter int STEP_CYC0 = sbc_cfg_pkg::STEP_CYC0,
    parameter int STEP_CYC1 = sbc_cfg_pkg::STEP_CYC1,
    parameter int STEP_CYC2 = sbc_cfg_pkg::STEP_CYC2,
    parameter int STEP_CYC3 = sbc_cfg_pkg::STEP_CYC3
) (
    input  wire logic       mclk_i,    // system clock
    input  wire logic       rst_n_i,   // async reset, active low
    input  wire logic [7:0] duty_i,    // duty register
    input  wire logic [1:0] rate_i,    // rate select register
    output logic            on_o,      // switch on level
    output logic            wrap_o     // last cycle of a period
);
    localparam int CW = sbc_cfg_pkg::STEP_CNT_W;
    logic [CW-1:0] pres;
    logic [7:0]    step;
    logic [7:0]    duty_act;
    logic [1:0]    rate_act;
    logic [CW-1:0] step_len;
    logic          step_end;

    // step length from the rate in force, not the written one
    assign step_len = (rate_act == 2'h0) ? CW'(STEP_CYC0) :
                      (rate_act == 2'h1) ? CW'(STEP_CYC1) :
                      (rate_act == 2'h2) ? CW'(STEP_CYC2) :
                                           CW'(STEP_CYC3);
    assign step_end = (pres == step_len - CW'(1));
    assign wrap_o   = step_end && (step == 8'(sbc_cfg_pkg::PWM_STEPS - 1));

    // step counter and period-boundary latch
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pres     <= '0;
            step     <= 8'h00;
            duty_act <= sbc_cfg_pkg::DUTY_POR;
            rate_act <= sbc_cfg_pkg::RATE_POR;
        end else begin
            pres <= step_end ? '0 : pres + CW'(1);
            if (wrap_o) begin
                step     <= 8'h00;
                duty_act <= duty_i;
                rate_act <= rate_i;
            end else if (step_end) begin
                step <= step + 8'h01;
            end
        end
    end

    // 0 never reaches, 255 is above every step: off and always on fall out
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_o <= 1'b0;
        end else begin
            on_o <= (step < duty_act);
        end
    end

    a_duty_zero_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        on_o |-> $past(duty_act) != sbc_cfg_pkg::DUTY_OFF)
        else $error("switch on with zero duty");
    a_duty_full_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(duty_act) == sbc_cfg_pkg::DUTY_FULL |-> on_o)
        else $error("switch off with full duty");
    a_duty_mid_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !wrap_o |=> $stable(duty_act) && $stable(rate_act))
        else $error("duty or rate changed inside a period");
endmodule
`default_nettype wire

// ==== hdl/wake_filter.sv ====
/*
  static wake filter: the pin level is synchronised, then must hold for
  the full filter time before the filtered level follows it.
  assumes the pin is asynchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_filter (
    input  wire logic mclk_i,    // system clock
    input  wire logic rst_n_i,   // async reset, active low
    input  wire logic pin_i,     // raw pin level, asynchronous
    output logic      level_o,   // filtered level
    output logic      edge_o     // one-cycle pulse on filtered change
);
    localparam int CW = sbc_cfg_pkg::WAKE_CNT_W;
    localparam logic [CW-1:0] LAST = CW'(sbc_cfg_pkg::WAKE_FILTER_CYC - 1);
    logic          sync1;
    logic          sync2;
    logic [CW-1:0] cnt;
    logic          differs;

    assign differs = (sync2 != level_o);

    // two-stage synchroniser, then stability counter
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1   <= 1'b0;
            sync2   <= 1'b0;
            cnt     <= '0;
            level_o <= 1'b0;
            edge_o  <= 1'b0;
        end else begin
            sync1  <= pin_i;
            sync2  <= sync1;
            edge_o <= 1'b0;
            if (!differs) begin
                cnt <= '0;                   // a glitch restarts the wait
            end else if (cnt == LAST) begin
                cnt     <= '0;
                level_o <= sync2;
                edge_o  <= 1'b1;
            end else begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    a_filter_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(level_o) |-> $past(cnt) == LAST)
        else $error("wake level changed before filter time");
endmodule
`default_nettype wire

// ==== hdl/pin_pwm_cfg.sv ====
/*
  spi-reached configuration of the high-voltage pin function, pwm duty
  and rate, thermal trip level and regulator current limit.
  assumes an spi master on the pins, lock bits and mode events from the
  neighbouring registers on mclk_i.
*/
// Contract
// - codes 0-2 fail output, 3 timer high-side, 4 off
// - code 5 wake input, 16 us filter
// - code 6 pwm low-side, 7 pwm high-side
// - wake input is default fail-safe wake source
// - pin mode zero at power-on, kept by restart
// - level-0 lock keeps pin mode on soft reset
// - duty zero keeps switch off
// - duty all ones on, else duty/255 on
// - new duty waits for period end
// - rate codes give 100, 200, 325, 400 hz
// - new rate waits for period end
// - duty, rate clear on power-on, soft reset
// - bit 2 selects higher thermal trip level
// - two-bit regulator current limit, default 01
// - reserved bits read zero, ignore writes
// - hardware control 0x01 at power-on, level-1 lock
// - level-0 lock blocks pin mode writes
// - locks take hold at chip select rise
`timescale 1ns/1ps
`default_nettype none
module pin_pwm_cfg #(
    parameter int STEP_CYC0 = sbc_cfg_pkg::STEP_CYC0  // 100 hz step, cycles
) (
    input  wire logic       mclk_i,          // system clock, 125 mhz
    input  wire logic       rst_n_i,         // power-on reset, active low
    input  wire logic       spi_sclk_i,      // spi clock pin
    input  wire logic       spi_sdi_i,       // spi data in pin
    input  wire logic       spi_chip_select_n_i, // spi select, low active
    output logic            spi_sdo_o,       // spi data out
    output logic            spi_sdo_oe_o,    // sdo driven while selected
    input  wire logic       soft_reset_i,    // soft reset pulse
    input  wire logic       restart_i,       // restart pulse
    input  wire logic       cfg_lock0_i,     // level-0 lock register bit
    input  wire logic       cfg_lock1_i,     // level-1 lock register bit
    input  wire logic       fail_safe_mode_i, // device in fail-safe mode
    input  wire logic       fail_output_i,   // fail output request level
    input  wire logic       sense_timer_i,   // cyclic sense timer level
    input  wire logic       gpio_pin_i,      // pin level, asynchronous
    output logic [5:0]      pin_func_o,      // one-hot pin function
    output logic            high_side_switch_o, // high-side drive on
    output logic            low_side_switch_o,  // low-side drive on
    output logic            wake_event_o,    // filtered wake edge pulse
    output logic            wake_source_default_o, // fail-safe wake src
    output logic            thermal_trip_level_o,  // 1: higher trip level
    output logic [1:0]      regulator_current_limit_o, // limit step
    output logic            charge_pump_wr_en_o // charge pump bit writable
);
    // spi pin synchronisers: stage one is read only by stage two
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic       sclk_s, sdi_s, csn_s;
    logic       sclk_rise, sclk_fall, cs_rise, cs_fall;

    // frame state
    logic [4:0] bit_cnt;
    logic [7:0] rx;
    logic [6:0] addr_q;
    logic       wr_flag;
    logic [7:0] tx;
    logic       wr_stb;
    logic [7:0] wdata;
    logic [7:0] next_rx;
    logic [7:0] rdata;

    // configuration state
    logic [2:0] pin_mode;
    logic [7:0] duty_setting;
    logic [1:0] period_rate_select;
    logic       trip_level;
    logic [1:0] ilim;
    logic       lock0_eff;
    logic       lock1_eff;

    logic       wr_pin, wr_duty, wr_rate, wr_hw;
    logic       pwm_on, pwm_wrap, wake_level;
    logic       wake_edge;
    sbc_cfg_pkg::pin_mode_t mode;

    assign {sclk_s, sdi_s, csn_s} = sync2;
    assign sclk_rise = sclk_s && !prev[2] && !csn_s;
    assign sclk_fall = !sclk_s && prev[2] && !csn_s;
    assign cs_rise   = csn_s && !prev[0];
    assign cs_fall   = !csn_s && prev[0];
    assign next_rx   = {sdi_s, rx[7:1]};

    // pins pass two flip-flops before anything looks at them
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 3'h1;
            sync2 <= 3'h1;
            prev  <= 3'h1;
        end else begin
            sync1 <= {spi_sclk_i, spi_sdi_i, spi_chip_select_n_i};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // frame receive: address byte then data byte, lsb first
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt <= 5'h00;
            rx      <= 8'h00;
            addr_q  <= 7'h00;
            wr_flag <= 1'b0;
            wr_stb  <= 1'b0;
            wdata   <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (cs_fall) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise && bit_cnt != sbc_cfg_pkg::SPI_DONE) begin
                rx      <= next_rx;
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == sbc_cfg_pkg::SPI_LAST_CMD_BIT) begin
                    addr_q  <= next_rx[6:0];
                    wr_flag <= next_rx[7];
                end
                if (bit_cnt == sbc_cfg_pkg::SPI_LAST_BIT) begin
                    wr_stb <= wr_flag;
                    wdata  <= next_rx;
                end
            end
        end
    end

    // read data shifts out on falling edges of the second byte
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx <= 8'h00;
        end else if (cs_fall) begin
            tx <= 8'h00;
        end else if (sclk_fall && bit_cnt == sbc_cfg_pkg::SPI_FIRST_DAT_BIT) begin
            tx <= rdata;
        end else if (sclk_fall && bit_cnt > sbc_cfg_pkg::SPI_FIRST_DAT_BIT) begin
            tx <= {1'b0, tx[7:1]};
        end
    end
    assign spi_sdo_o    = tx[0];
    assign spi_sdo_oe_o = !csn_s;

    // read mux: reserved bits are constant zero, unmapped reads zero
    assign rdata =
        (addr_q == sbc_cfg_pkg::ADDR_PIN_FUNC) ? {5'h00, pin_mode} :
        (addr_q == sbc_cfg_pkg::ADDR_DUTY)     ? duty_setting :
        (addr_q == sbc_cfg_pkg::ADDR_RATE)     ? {6'h00, period_rate_select} :
        (addr_q == sbc_cfg_pkg::ADDR_HWCTL)    ?
            {5'h00, trip_level, ilim} : 8'h00;

    // write decode; locked fields simply drop the write
    assign wr_pin  = wr_stb && addr_q == sbc_cfg_pkg::ADDR_PIN_FUNC
                     && !lock0_eff;
    assign wr_duty = wr_stb && addr_q == sbc_cfg_pkg::ADDR_DUTY;
    assign wr_rate = wr_stb && addr_q == sbc_cfg_pkg::ADDR_RATE;
    assign wr_hw   = wr_stb && addr_q == sbc_cfg_pkg::ADDR_HWCTL
                     && !lock1_eff;
    assign charge_pump_wr_en_o = !lock0_eff;

    // locks only bite once the frame that set them has ended;
    // level 1 holds until power-on reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock0_eff <= 1'b0;
            lock1_eff <= 1'b0;
        end else if (cs_rise) begin
            lock0_eff <= cfg_lock0_i;
            lock1_eff <= lock1_eff | cfg_lock1_i;
        end
    end

    // pin mode: restart keeps it, soft reset clears unless locked
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_mode <= sbc_cfg_pkg::PIN_MODE_POR;
        end else if (soft_reset_i) begin
            if (!lock0_eff) begin
                pin_mode <= sbc_cfg_pkg::PIN_MODE_POR;
            end
        end else if (wr_pin && !restart_i) begin
            pin_mode <= wdata[2:0];
        end
    end

    // duty and rate: cleared by soft reset, kept by restart
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            duty_setting       <= sbc_cfg_pkg::DUTY_POR;
            period_rate_select <= sbc_cfg_pkg::RATE_POR;
        end else if (soft_reset_i) begin
            duty_setting       <= sbc_cfg_pkg::DUTY_POR;
            period_rate_select <= sbc_cfg_pkg::RATE_POR;
        end else if (!restart_i) begin
            if (wr_duty) begin
                duty_setting <= wdata;
            end
            if (wr_rate) begin
                period_rate_select <= wdata[1:0];
            end
        end
    end

    // thermal and current limit: level-1 lock shields from soft reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trip_level <= sbc_cfg_pkg::HWCTL_POR[sbc_cfg_pkg::TRIP_POS];
            ilim       <= sbc_cfg_pkg::HWCTL_POR[1:0];
        end else if (soft_reset_i) begin
            if (!lock1_eff) begin
                trip_level <= sbc_cfg_pkg::TRIP_POR;
                ilim       <= sbc_cfg_pkg::ILIM_POR;
            end
        end else if (wr_hw && !restart_i) begin
            trip_level <= wdata[sbc_cfg_pkg::TRIP_POS];
            ilim       <= wdata[1:0];
        end
    end
    assign thermal_trip_level_o      = trip_level;
    assign regulator_current_limit_o = ilim;

    // pin function decode, exactly one bit set for every code
    assign mode = sbc_cfg_pkg::pin_mode_t'(pin_mode);
    assign pin_func_o[sbc_cfg_pkg::FN_FAIL] =
        (mode == sbc_cfg_pkg::PM_FAIL0) || (mode == sbc_cfg_pkg::PM_FAIL1)
        || (mode == sbc_cfg_pkg::PM_FAIL2);
    assign pin_func_o[sbc_cfg_pkg::FN_HS_TM] =
        (mode == sbc_cfg_pkg::PM_HS_TIMER);
    assign pin_func_o[sbc_cfg_pkg::FN_OFF]  = (mode == sbc_cfg_pkg::PM_OFF);
    assign pin_func_o[sbc_cfg_pkg::FN_WAKE] = (mode == sbc_cfg_pkg::PM_WAKE);
    assign pin_func_o[sbc_cfg_pkg::FN_LS_PW] =
        (mode == sbc_cfg_pkg::PM_LS_PWM);
    assign pin_func_o[sbc_cfg_pkg::FN_HS_PW] =
        (mode == sbc_cfg_pkg::PM_HS_PWM);

    // drive: fail output pulls low, timer or pwm gate the switches;
    // pwm only reads the duty set beforehand if the master set it first
    assign high_side_switch_o =
        (pin_func_o[sbc_cfg_pkg::FN_HS_TM] && sense_timer_i)
        || (pin_func_o[sbc_cfg_pkg::FN_HS_PW] && pwm_on);
    assign low_side_switch_o =
        (pin_func_o[sbc_cfg_pkg::FN_FAIL] && fail_output_i)
        || (pin_func_o[sbc_cfg_pkg::FN_LS_PW] && pwm_on);

    // wake only counts while the pin is a wake input
    assign wake_event_o = wake_edge && pin_func_o[sbc_cfg_pkg::FN_WAKE];
    assign wake_source_default_o =
        pin_func_o[sbc_cfg_pkg::FN_WAKE] && fail_safe_mode_i;

    pwm_gen #(
        .STEP_CYC0 (STEP_CYC0)
    ) u_pwm (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .duty_i  (duty_setting),
        .rate_i  (period_rate_select),
        .on_o    (pwm_on),
        .wrap_o  (pwm_wrap)
    );

    wake_filter u_wake (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (gpio_pin_i),
        .level_o (wake_level),
        .edge_o  (wake_edge)
    );

    sequence s_lock0_armed;
        cfg_lock0_i && cs_rise;
    endsequence

    a_lock_arms: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_lock0_armed |=> lock0_eff)
        else $error("level-0 lock not taken at select rise");
    a_lock_waits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !cs_rise |=> $stable(lock0_eff))
        else $error("level-0 lock moved inside a frame");
    a_pin_locked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        lock0_eff |=> $stable(pin_mode))
        else $error("pin mode changed while locked");
    a_hw_locked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        lock1_eff |=> $stable(trip_level) && $stable(ilim))
        else $error("hardware control changed while locked");
    a_soft_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        soft_reset_i |=> duty_setting == 8'h00
                         && period_rate_select == 2'h0)
        else $error("soft reset left duty or rate set");
    a_restart_keeps: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        restart_i && !soft_reset_i |=> $stable(duty_setting)
                         && $stable(pin_mode))
        else $error("restart changed configuration");
    a_func_onehot: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $onehot(pin_func_o))
        else $error("pin function not one-hot");
    a_write_applies: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_pin && !soft_reset_i && !restart_i
        |=> pin_mode == $past(wdata[2:0]))
        else $error("pin mode write not applied");
endmodule
`default_nettype wire

// ==== verif/spi_master_model.sv ====
/*
  spi master model standing in for the microcontroller.
  assumes it runs from the mclk_i of the configuration block.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input  wire logic mclk_i,   // system clock
    input  wire logic sdo_i,    // data from device
    output logic      sclk_o,   // spi clock, still outside frames
    output logic      sdi_o,    // data to device
    output logic      csn_n_o   // chip select, low active
);
    initial begin
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        csn_n_o = 1'b1;
    end
    // address, write flag, data, lsb first; 4 mclk per phase so the
    // device synchroniser sees every level
    task automatic xfer(input logic [6:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {d, w, a};
        q = 8'h00;
        @(posedge mclk_i) csn_n_o <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            sdi_o <= f[i];
            sclk_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
            if (i > 7) q[i-8] = sdo_i;
            sclk_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
        end
        sclk_o <= 1'b0;
        sdi_o <= ~f[15];   // released line shows no stale bit
        csn_n_o <= 1'b1;   // lock bits taken on this rise
        repeat (8) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  self-checking bench for the pin, pwm and limit configuration block.
  assumes the spi master model and a shortened 100 hz step.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int STEP = 4;   // short step keeps a period at 1020 cycles
    localparam logic [5:0] FX [8] = '{6'h01, 6'h01, 6'h01, 6'h02,
                                      6'h04, 6'h08, 6'h10, 6'h20};
    logic mclk_i = 1'b0, rst_n_i = 1'b0, sclk, sdi, csn_n, sdo, hs;
    logic soft_rst = 1'b0, rstrt = 1'b0, lk0 = 1'b0, lk1 = 1'b0;
    logic fsm = 1'b0, trip, wsrc, charge_pump_enable, gpin = 1'b0, wev;
    logic [5:0] func;
    logic [1:0] ilim;
    logic [7:0] q;
    int mismatches = 0, n_tests = 0, on_cnt;
    always #4 mclk_i = ~mclk_i;
    spi_master_model spi_master_model_i (.mclk_i(mclk_i), .sdo_i(sdo),
        .sclk_o(sclk), .sdi_o(sdi), .csn_n_o(csn_n));
    pin_pwm_cfg #(.STEP_CYC0(STEP)) pin_pwm_cfg_i (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
        .spi_chip_select_n_i(csn_n), .spi_sdo_o(sdo), .spi_sdo_oe_o(),
        .soft_reset_i(soft_rst), .restart_i(rstrt), .cfg_lock0_i(lk0),
        .cfg_lock1_i(lk1), .fail_safe_mode_i(fsm), .fail_output_i(1'b0),
        .sense_timer_i(1'b0), .gpio_pin_i(gpin), .pin_func_o(func),
        .high_side_switch_o(hs), .low_side_switch_o(), .wake_event_o(wev),
        .wake_source_default_o(wsrc), .thermal_trip_level_o(trip),
        .regulator_current_limit_o(ilim), .charge_pump_wr_en_o(charge_pump_enable));
    task automatic chk(input string n, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi_master_model_i.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        spi_master_model_i.xfer(a, 1'b0, 8'h00, q);
        chk("read", 16'(q), 16'(e));
    endtask
    // k 0 gives a soft reset pulse, else a restart pulse
    task automatic pulse(input int k);
        if (k == 0) soft_rst <= 1'b1;
        else rstrt <= 1'b1;
        @(posedge mclk_i);
        soft_rst <= 1'b0;
        rstrt <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    // any 1020 cycles hold exactly one whole period of the output
    task automatic meas(input logic [7:0] d);
        wr(7'h18, d);
        repeat (2 * 255 * STEP) @(posedge mclk_i);
        on_cnt = 0;
        repeat (255 * STEP) begin
            @(posedge mclk_i);
            on_cnt += int'(hs);
        end
        chk("pwm on", 16'(on_cnt), 16'(d * STEP));
    endtask
    task automatic close_out();
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        rd(7'h17, 8'h00);
        rd(7'h18, 8'h00);
        rd(7'h1c, 8'h00);
        rd(7'h1d, 8'h01);
        rd(7'h30, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(7'h17, 8'hf8 | 8'(m));
            rd(7'h17, 8'(m));
            chk("func", 16'(func), 16'(FX[m]));
        end
        wr(7'h1d, 8'hfe);
        rd(7'h1d, 8'h06);
        chk("trip", 16'(trip), 16'h1);
        chk("ilim", 16'(ilim), 16'h2);
        wr(7'h17, 8'h04);
        wr(7'h18, 8'h00);
        wr(7'h17, 8'h07);
        meas(8'h00);
        meas(8'h80);
        meas(8'hff);
        // rate code 3 only after the measurements: its period is very long
        wr(7'h1c, 8'hff);
        rd(7'h1c, 8'h03);
        wr(7'h1c, 8'h00);
        fsm <= 1'b1;
        wr(7'h17, 8'h05);
        chk("wake src", 16'(wsrc), 16'h1);
        // pin must hold 2000 cycles before the filtered edge shows
        gpin <= 1'b1;
        on_cnt = 0;
        repeat (1990) begin
            @(posedge mclk_i);
            on_cnt += int'(wev);
        end
        chk("wake early", 16'(on_cnt), 16'h0);
        repeat (20) begin
            @(posedge mclk_i);
            on_cnt += int'(wev);
        end
        chk("wake event", 16'(on_cnt), 16'h1);
        wr(7'h18, 8'h5a);
        pulse(1);
        rd(7'h18, 8'h5a);
        rd(7'h17, 8'h05);
        pulse(0);
        rd(7'h18, 8'h00);
        rd(7'h1d, 8'h01);
        rd(7'h17, 8'h00);
        wr(7'h17, 8'h06);
        lk0 <= 1'b1;
        rd(7'h17, 8'h06);
        chk("cp wr", 16'(charge_pump_enable), 16'h0);
        wr(7'h17, 8'h04);
        rd(7'h17, 8'h06);
        pulse(0);
        rd(7'h17, 8'h06);
        lk1 <= 1'b1;
        wr(7'h1d, 8'h03);
        pulse(0);
        rd(7'h1d, 8'h03);
        wr(7'h1d, 8'h00);
        rd(7'h1d, 8'h03);
        close_out();
    end
    // watchdog: the run needs some 20000 cycles
    initial begin
        repeat (100000) @(posedge mclk_i);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
